/* File: logic/autoreload_pwm_compare_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module autoreload_pwm_compare_regs #(
    parameter int LITE_CYCLES = pwm_regs_pkg::LITE_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire pwm_regs_pkg::apb_req_s apb_req,
    output pwm_regs_pkg::apb_rsp_s apb_rsp,
    // Channel pin
    output pwm_regs_pkg::pin_s pin
);
    import pwm_regs_pkg::*;

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [1:0] clk_sel;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic [3:0] reload_high;
    logic [7:0] reload_low;
    logic channel_output_enable;
    logic output_polarity;
    logic compare_flag;
    logic [3:0] duty_high;
    logic [7:0] duty_low;
    logic [11:0] upcounter_value;
    logic [11:0] shadow_duty;
    logic pwm_level;
    logic counted;
    logic overflow_evt;
    cmp_state_e cmp_state;
    logic tick;

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic at_index(input logic [7:0] addr, input logic [7:0] idx);
        return addr == 8'(idx << 2);
    endfunction

    wire [7:0] a = apb_req.paddr;
    wire setup = apb_req.psel && !apb_req.penable;
    wire access = apb_req.psel && apb_req.penable && apb_rsp.pready;
    wire wr = access && apb_req.pwrite;
    wire rd = access && !apb_req.pwrite;
    wire [7:0] wd = apb_req.pwdata[7:0];
    wire hit_tcs = at_index(a, IDX_TIMER_CTRL_STATUS);
    wire hit_cnth = at_index(a, IDX_COUNTER_HIGH);
    wire hit_cntl = at_index(a, IDX_COUNTER_LOW);
    wire hit_rlh = at_index(a, IDX_RELOAD_HIGH);
    wire hit_rll = at_index(a, IDX_RELOAD_LOW);
    wire hit_oc = at_index(a, IDX_OUTPUT_CONTROL);
    wire hit_ccs = at_index(a, IDX_CHANNEL_CTRL_STATUS);
    wire hit_dh = at_index(a, IDX_DUTY_HIGH);
    wire hit_dl = at_index(a, IDX_DUTY_LOW);
    wire mapped = hit_tcs || hit_cnth || hit_cntl || hit_rlh || hit_rll || hit_oc || hit_ccs || hit_dh || hit_dl;

    // ==========================================================
    // Assembled values
    // ==========================================================
    wire [11:0] reload_value = {reload_high, reload_low};
    wire [11:0] duty_value = {duty_high, duty_low};
    wire pwm_mode = channel_output_enable;
    // PWM compares with the shadow; compare mode uses the live value
    wire [11:0] cmp_value = pwm_mode ? shadow_duty : duty_value;
    wire cmp_locked = (cmp_state == CMP_LOCKED);
    // Zero compare value disables compare mode; matches the reset value
    wire cmp_allowed = pwm_mode || (duty_value != COMPARE_OFF);
    wire match = counted && !cmp_locked && cmp_allowed && (upcounter_value == cmp_value);

    // Read multiplexer; reserved bits stay zero
    wire [7:0] tcs_rd = {3'h0, clk_sel, overflow_flag, overflow_irq_enable, compare_irq_enable};
    wire [7:0] ccs_rd = {6'h00, output_polarity, compare_flag};
    wire [7:0] rd_byte = hit_tcs ? tcs_rd :
                         hit_cnth ? {4'h0, upcounter_value[11:8]} :
                         hit_cntl ? upcounter_value[7:0] :
                         hit_rlh ? {4'h0, reload_high} :
                         hit_rll ? reload_low :
                         hit_oc ? {7'h00, channel_output_enable} :
                         hit_ccs ? ccs_rd :
                         hit_dh ? {4'h0, duty_high} :
                         hit_dl ? duty_low : 8'h00;

    // Flags cleared only for bits the read actually returned, so a set
    // that lands between setup and access survives
    wire clr_ovf = rd && hit_tcs && apb_rsp.prdata[TCS_OVERFLOW_FLAG];
    wire clr_cmp = rd && hit_ccs && apb_rsp.prdata[CCS_COMPARE_FLAG];
    wire next_overflow_flag = overflow_evt || (overflow_flag && !clr_ovf);
    wire next_compare_flag = match || (compare_flag && !clr_cmp);
    wire wrap = tick && (upcounter_value == COUNT_MAX);
    wire [11:0] next_count = wrap ? reload_value : 12'(upcounter_value + 1'b1);

    // ==========================================================
    // APB response: one access cycle, registered
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= setup;
            apb_rsp.pslverr <= setup && !mapped;
            apb_rsp.prdata <= (setup && !apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ==========================================================
    // Software written fields
    // ==========================================================
    // Writes to counter registers and reserved bits have no target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sel <= 2'h0;
            overflow_irq_enable <= 1'b0;
            compare_irq_enable <= 1'b0;
            reload_high <= 4'h0;
            reload_low <= REG_RESET;
            channel_output_enable <= 1'b0;
            output_polarity <= 1'b0;
            duty_high <= 4'h0;
            duty_low <= REG_RESET;
        end else if (wr) begin
            if (hit_tcs) begin
                clk_sel <= wd[TCS_CLK_SEL_LSB +: 2];
                overflow_irq_enable <= wd[TCS_OVERFLOW_IRQ_EN];
                compare_irq_enable <= wd[TCS_COMPARE_IRQ_EN];
            end
            if (hit_rlh) begin
                reload_high <= wd[3:0];
            end
            if (hit_rll) begin
                reload_low <= wd;
            end
            if (hit_oc) begin
                channel_output_enable <= wd[OC_OUTPUT_ENABLE];
            end
            if (hit_ccs) begin
                output_polarity <= wd[CCS_POLARITY];
            end
            if (hit_dh) begin
                duty_high <= wd[3:0];
            end
            if (hit_dl) begin
                duty_low <= wd;
            end
        end
    end

    // ==========================================================
    // Compare lock: high byte write suspends, low byte resumes
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_state <= CMP_RUN;
        end else begin
            unique case (cmp_state)
                CMP_RUN: if (wr && hit_dh) cmp_state <= CMP_LOCKED;
                CMP_LOCKED: if (wr && hit_dl) cmp_state <= CMP_RUN;
            endcase
        end
    end

    // ==========================================================
    // Counter clock and upcounter
    // ==========================================================
    count_tick_gen #(
        .LITE_CYCLES(LITE_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .clk_sel(clk_sel),
        .tick(tick)
    );

    // Counted marks the cycle after an advance, so a match is seen once
    // even when the slow timebase holds the counter for many cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upcounter_value <= COUNT_RESET;
            counted <= 1'b0;
            overflow_evt <= 1'b0;
        end else begin
            if (tick) begin
                upcounter_value <= next_count;
            end
            counted <= tick;
            overflow_evt <= wrap;
        end
    end

    // ==========================================================
    // Flags, shadow duty and waveform
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
            compare_flag <= 1'b0;
        end else begin
            overflow_flag <= next_overflow_flag;
            compare_flag <= next_compare_flag;
        end
    end

    // Shadow is loaded every overflow, even half written; low wins over
    // high so duty equal to reload gives a flat low signal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_duty <= COMPARE_OFF;
            pwm_level <= 1'b0;
        end else begin
            if (overflow_evt) begin
                shadow_duty <= duty_value;
            end
            if (pwm_mode && match) begin
                pwm_level <= 1'b0;
            end else if (pwm_mode && overflow_evt) begin
                pwm_level <= 1'b1;
            end
        end
    end

    // Pin: enable is active low, out is polarity applied
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= '{out: 1'b0, oe_n: 1'b1};
        end else begin
            pin.out <= pwm_level ^ output_polarity;
            pin.oe_n <= !channel_output_enable;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_DUTY_HIGH_NIBBLE: assert property (@(posedge clk) disable iff (!rst_n)
        wr && hit_dh |=> duty_value[11:8] == $past(apb_req.pwdata[3:0]))
        else $error("duty high nibble not stored");

    AST_PWM_GOES_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        pwm_mode && overflow_evt && !match |=> pwm_level)
        else $error("pwm level not raised at overflow");

    AST_OC_USES_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !pwm_mode |-> cmp_value == duty_value)
        else $error("compare mode not using duty value");

    AST_POLARITY_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 pin.out == ($past(pwm_level) ^ $past(output_polarity)))
        else $error("pin level ignores polarity");

    AST_FLAG_ON_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
        match |=> compare_flag ##1 (compare_flag || $past(clr_cmp)))
        else $error("compare flag not held after match");

    AST_FLAG_READ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clr_cmp && !match |=> !compare_flag)
        else $error("compare flag not cleared by read");

    AST_PIN_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(channel_output_enable) |=> !pin.oe_n)
        else $error("pin not handed to channel");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000 && (!hit_ccs || apb_rsp.prdata[7:2] == 6'h00))
        else $error("reserved bits read nonzero");

    AST_RELOAD_ON_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        wrap |=> upcounter_value == $past(reload_value) ##1 overflow_flag)
        else $error("counter not reloaded at wrap");

    AST_SHADOW_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        overflow_evt |=> shadow_duty == $past(duty_value))
        else $error("shadow not loaded at overflow");

    AST_PWM_GOES_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        pwm_mode && match |=> !pwm_level ##1 pin.out == $past(output_polarity))
        else $error("pwm level not dropped on match");

    AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        wr && hit_dh |=> (cmp_locked && !match)[*2])
        else $error("compare ran while suspended");

    AST_COUNTER_RO: assert property (@(posedge clk) disable iff (!rst_n)
        wr && (hit_cntl || hit_cnth) && !tick |=> $stable(upcounter_value))
        else $error("counter changed by write");

    AST_READY_AFTER_SETUP: assert property (@(posedge clk) disable iff (!rst_n)
        setup |=> apb_rsp.pready)
        else $error("no ready after setup");

    AST_READY_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
        apb_rsp.pready && apb_req.penable |=> !apb_rsp.pready)
        else $error("ready held past access");

    AST_UNMAPPED_ERROR: assert property (@(posedge clk) disable iff (!rst_n)
        setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
        else $error("unmapped access not refused");

    AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_n)
        overflow_evt |=> overflow_flag)
        else $error("overflow flag not set");

    AST_OVF_READ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clr_ovf && !overflow_evt |=> !overflow_flag)
        else $error("overflow flag not cleared by read");

    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !wrap |=> upcounter_value == $past(upcounter_value) + 12'h001)
        else $error("counter did not step by one");

    AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> $stable(upcounter_value))
        else $error("counter moved without a tick");

    AST_OC_NO_WAVE: assert property (@(posedge clk) disable iff (!rst_n)
        !pwm_mode |=> $stable(pwm_level))
        else $error("waveform moved in compare mode");

    AST_OC_ZERO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !pwm_mode && duty_value == COMPARE_OFF |-> !match)
        else $error("compare ran with zero duty value");

    AST_SHADOW_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !overflow_evt |=> $stable(shadow_duty))
        else $error("shadow changed between overflows");

    AST_LOCK_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        cmp_locked && wr && hit_dl |=> !cmp_locked)
        else $error("low byte write did not resume compare");

    AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        !channel_output_enable |=> pin.oe_n)
        else $error("pin driven while disabled");

    AST_COUNT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        setup && !apb_req.pwrite && hit_cntl |=> apb_rsp.prdata[7:0] == $past(upcounter_value[7:0]))
        else $error("counter low read not live");

endmodule
`default_nettype wire

/* File: common/pwm_regs_pkg.sv */
package pwm_regs_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [7:0] IDX_TIMER_CTRL_STATUS = 8'h0d;
    localparam logic [7:0] IDX_COUNTER_HIGH = 8'h0e;
    localparam logic [7:0] IDX_COUNTER_LOW = 8'h0f;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'h10;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'h11;
    localparam logic [7:0] IDX_OUTPUT_CONTROL = 8'h12;
    localparam logic [7:0] IDX_CHANNEL_CTRL_STATUS = 8'h13;
    localparam logic [7:0] IDX_DUTY_HIGH = 8'h17;
    localparam logic [7:0] IDX_DUTY_LOW = 8'h18;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int TCS_CLK_SEL_LSB = 3;
    localparam int TCS_OVERFLOW_FLAG = 2;
    localparam int TCS_OVERFLOW_IRQ_EN = 1;
    localparam int TCS_COMPARE_IRQ_EN = 0;
    localparam int CCS_POLARITY = 1;
    localparam int CCS_COMPARE_FLAG = 0;
    localparam int OC_OUTPUT_ENABLE = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] COUNT_RESET = 12'h000;
    localparam logic [11:0] COUNT_MAX = 12'hfff;
    localparam logic [11:0] COMPARE_OFF = 12'h000;

    // ==========================================================
    // Counter clock selection codes
    // ==========================================================
    localparam logic [1:0] CLK_SEL_OFF = 2'h0;
    localparam logic [1:0] CLK_SEL_LITE = 2'h1;
    localparam logic [1:0] CLK_SEL_CPU = 2'h2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LITE_PERIOD_US = 1000;
    localparam int LITE_TICK_CYCLES = (LITE_PERIOD_US * 1000000) / CLK_PERIOD_PS;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_s;

    typedef enum logic {CMP_RUN, CMP_LOCKED} cmp_state_e;

endpackage

/* File: logic/count_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen #(
    parameter int LITE_CYCLES = pwm_regs_pkg::LITE_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection
    input wire logic [1:0] clk_sel,
    // Counter advance pulse
    output logic tick
);
    import pwm_regs_pkg::*;

    // ==========================================================
    // Prescaler for the slow timebase
    // ==========================================================
    localparam int DW = $clog2(LITE_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(LITE_CYCLES - 1);

    logic [DW-1:0] div;
    wire div_wrap = (div == DIV_LAST);
    wire [DW-1:0] next_div = div_wrap ? '0 : DW'(div + 1'b1);
    wire next_tick = (clk_sel == CLK_SEL_CPU) || ((clk_sel == CLK_SEL_LITE) && div_wrap);

    // Divider runs free so a selection change needs no restart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
            tick <= 1'b0;
        end else begin
            div <= next_div;
            tick <= next_tick;
        end
    end

endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t %s got %h exp %h", $time, msg, a, e); end end
module testbench;
    import pwm_regs_pkg::*;

    // ==========================================================
    // Signals and bookkeeping
    // ==========================================================
    logic clk;
    logic rst_n;
    apb_req_s req;
    apb_rsp_s rsp;
    pin_s pin;
    int miscompares = 0;
    int n_compared = 0;
    string msg = "boot";
    logic [31:0] seed = 32'd7;
    logic [7:0] rd;
    logic [7:0] cnt;
    logic [7:0] tcs_val;
    logic err;
    logic [11:0] dty;
    int hi;
    logic [7:0] regs [9] = '{IDX_TIMER_CTRL_STATUS, IDX_COUNTER_HIGH, IDX_COUNTER_LOW, IDX_RELOAD_HIGH,
        IDX_RELOAD_LOW, IDX_OUTPUT_CONTROL, IDX_CHANNEL_CTRL_STATUS, IDX_DUTY_HIGH, IDX_DUTY_LOW};

    // Short slow-tick count keeps the run brief
    autoreload_pwm_compare_regs #(.LITE_CYCLES(8)) dut (
        .clk(clk),
        .rst_n(rst_n),
        .apb_req(req),
        .apb_rsp(rsp),
        .pin(pin)
    );

    // ==========================================================
    // Clock and helpers
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Repeatable pseudo-random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Writable bits of each register but timer control/status, which gets zero; reserved bits read zero
    function automatic logic [7:0] wmask(input logic [7:0] idx);
        case (idx)
            IDX_RELOAD_HIGH, IDX_DUTY_HIGH: return 8'h0f;
            IDX_RELOAD_LOW, IDX_DUTY_LOW: return 8'hff;
            IDX_OUTPUT_CONTROL: return 8'h01;
            IDX_CHANNEL_CTRL_STATUS: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction

    // High cycles of the pin over 160 cycles, from reload and duty
    function automatic int exp_high(input int d, input int rl, input logic pol);
        int h;
        h = (160 / (4096 - rl)) * (d - rl);
        return pol ? 160 - h : h;
    endfunction

    // ==========================================================
    // APB master: one edge gap before every setup
    // ==========================================================
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rdat, output logic errf);
        int n;
        @(posedge clk);
        req.paddr <= {idx[5:0], 2'b00};
        req.pwrite <= wr;
        req.pwdata <= {24'h0, wd};
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        `CHK(rsp.pready, 1'b1)
        `CHK(rsp.prdata[31:8], 24'h0)
        rdat = rsp.prdata[7:0];
        errf = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdx(input logic [7:0] idx, output logic [7:0] r);
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Guard against a hung handshake
    initial begin
        #(20000 * 5);
        miscompares++;
        wrap_up();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        rst_n = 1'b0;
        req = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped slot
        msg = "reset";
        foreach (regs[i]) begin
            rdx(regs[i], rd);
            `CHK(rd, 8'h00)
        end
        apb(1'b0, 8'h14, 8'h00, rd, err);
        `CHK(err, 1'b1)
        `CHK(pin.oe_n, 1'b1)
        $display("test %s done", msg);
        // Random write and read back, reserved bits dropped
        msg = "rw";
        for (int i = 3; i < 9; i++) begin
            cnt = 8'(xs());
            wr(regs[i], cnt);
            rdx(regs[i], rd);
            `CHK(rd, cnt & wmask(regs[i]))
        end
        wr(IDX_COUNTER_LOW, 8'h55);
        rdx(IDX_COUNTER_LOW, rd);
        `CHK(rd, 8'h00)
        $display("test %s done", msg);
        // Counter runs from zero, wraps to the reload value
        msg = "count";
        wr(IDX_OUTPUT_CONTROL, 8'h00);
        wr(IDX_CHANNEL_CTRL_STATUS, 8'h00);
        wr(IDX_RELOAD_HIGH, 8'h0f);
        wr(IDX_RELOAD_LOW, 8'hf0);
        wr(IDX_DUTY_HIGH, 8'h0f);
        wr(IDX_DUTY_LOW, 8'hf8);
        tcs_val = 8'h10 | 8'(xs() & 32'h00000003);
        wr(IDX_TIMER_CTRL_STATUS, tcs_val);
        repeat (4200) @(posedge clk);
        rdx(IDX_COUNTER_HIGH, rd);
        `CHK(rd, 8'h0f)
        rdx(IDX_COUNTER_LOW, rd);
        `CHK(rd[7:4], 4'hf)
        rdx(IDX_TIMER_CTRL_STATUS, rd);
        `CHK(rd, tcs_val | 8'h04)
        $display("test %s done", msg);
        // Compare mode flag sets, then clears on read once stopped
        msg = "compare";
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        `CHK(rd, 8'h01)
        wr(IDX_TIMER_CTRL_STATUS, 8'h00);
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        rdx(IDX_COUNTER_LOW, cnt);
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        // A match on the last advance lands after the first read returned
        if (cnt != 8'hf8)
            `CHK(rd, 8'h00)
        $display("test %s done", msg);
        // High half alone suspends matching until the low half lands
        msg = "lock";
        wr(IDX_TIMER_CTRL_STATUS, 8'h10);
        wr(IDX_DUTY_HIGH, 8'h0f);
        repeat (4) @(posedge clk);
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        repeat (48) @(posedge clk);
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        `CHK(rd, 8'h00)
        wr(IDX_DUTY_LOW, 8'hf8);
        repeat (48) @(posedge clk);
        rdx(IDX_CHANNEL_CTRL_STATUS, rd);
        `CHK(rd, 8'h01)
        $display("test %s done", msg);
        // PWM duty measured at the pin, both polarities
        msg = "pwm";
        for (int p = 0; p < 2; p++) begin
            dty = 12'hff1 + 12'(xs() % 15);
            wr(IDX_DUTY_HIGH, {4'h0, dty[11:8]});
            wr(IDX_DUTY_LOW, dty[7:0]);
            wr(IDX_OUTPUT_CONTROL, 8'h01);
            wr(IDX_CHANNEL_CTRL_STATUS, {6'h0, p[0], 1'b0});
            repeat (40) @(posedge clk);
            hi = 0;
            repeat (160) begin
                @(posedge clk);
                if (pin.out === 1'b1)
                    hi++;
            end
            `CHK(hi, exp_high(dty, 12'hff0, p[0]))
            `CHK(pin.oe_n, 1'b0)
        end
        wr(IDX_OUTPUT_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        `CHK(pin.oe_n, 1'b1)
        $display("test %s done", msg);
        // Slow timebase: 40 cycles give five advances; code 3 stops counting
        msg = "slow";
        wr(IDX_TIMER_CTRL_STATUS, 8'h08);
        rdx(IDX_COUNTER_LOW, cnt);
        repeat (37) @(posedge clk);
        rdx(IDX_COUNTER_LOW, rd);
        `CHK(4'(rd - cnt), 4'h5)
        wr(IDX_TIMER_CTRL_STATUS, 8'h18);
        rdx(IDX_COUNTER_LOW, cnt);
        repeat (37) @(posedge clk);
        rdx(IDX_COUNTER_LOW, rd);
        `CHK(rd, cnt)
        $display("test %s done", msg);
        wrap_up();
    end
endmodule
`default_nettype wire
